// File: design/ddcn_mixer.sv
`timescale 1ns/100ps
// Real sample times complex oscillator, truncated back to 16 bits
module ddcn_mixer #(
	parameter int DW = 14
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Inputs
	input wire logic signed [DW-1:0] sample,
	input ddcn_pkg::ddcn_iq_s lo,
	// Output
	output ddcn_pkg::ddcn_iq_s bb
);

	logic signed [DW+15:0] prod_i;
	logic signed [DW+15:0] prod_q;

	assign prod_i = sample * lo.i;
	assign prod_q = sample * lo.q;

	// Keep the 16 bits below the top product bit; full-scale sine is 2^15
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bb <= '0;
		end else begin
			bb.i <= prod_i[DW+14 -: 16];
			bb.q <= prod_q[DW+14 -: 16];
		end
	end

endmodule // ddcn_mixer

// File: design/ddcn_osc.sv
`timescale 1ns/100ps
// Phase accumulator plus sine/cosine by quarter-wave lookup of 16 entries, 64 points per turn
module ddcn_osc #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic [W-1:0] freq_word,
	// Output
	output ddcn_pkg::ddcn_iq_s lo
);

	logic [W-1:0] phase_reg;
	logic [5:0] idx;
	logic signed [15:0] cos_v;
	logic signed [15:0] sin_v;

	// Sine table, one full turn in 64 steps
	function automatic logic signed [15:0] sine64(input logic [5:0] k);
		logic signed [15:0] t [0:15];
		logic signed [15:0] mag;
		t = '{16'sh0000, 16'sh0C8C, 16'sh18F9, 16'sh2528, 16'sh30FB, 16'sh3C56,
			16'sh471C, 16'sh5133, 16'sh5A82, 16'sh62F1, 16'sh6A6D, 16'sh70E2,
			16'sh7641, 16'sh7A7C, 16'sh7D89, 16'sh7F61};
		mag = 16'sh0000;
		unique case (k[5:4])
			2'b00: mag = t[k[3:0]];
			2'b01: mag = (k[3:0] == 4'h0) ? 16'sh7FFF : t[4'hF - k[3:0] + 4'h1];
			2'b10: mag = -t[k[3:0]];
			2'b11: mag = (k[3:0] == 4'h0) ? -16'sh7FFF : -t[4'hF - k[3:0] + 4'h1];
		endcase
		return mag;
	endfunction

	// Free-running: keeps phase continuous whether selected or not
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= '0;
		end else begin
			phase_reg <= phase_reg + freq_word; // Signed word wraps naturally
		end
	end

	assign idx = phase_reg[W-1 -: 6];
	assign cos_v = sine64(idx + 6'h10);
	assign sin_v = sine64(idx);

	// e^(-jwn) = cos - j sin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lo <= '0;
		end else begin
			lo.i <= cos_v;
			lo.q <= -sin_v;
		end
	end

endmodule // ddcn_osc

// File: design/ddcn_pkg.sv
package ddcn_pkg;

	// ******************************
	// Register map
	// ******************************
	localparam logic [15:0] ADDR_A_CTRL_SOURCE = 16'h500F;
	localparam logic [15:0] ADDR_A_CHOICE = 16'h5010;
	localparam logic [15:0] ADDR_A_PIN_ASSIGN = 16'h5438;
	localparam logic [15:0] ADDR_B_CTRL_SOURCE = 16'h580F;
	localparam logic [15:0] ADDR_B_CHOICE = 16'h5810;
	localparam logic [15:0] ADDR_B_PIN_ASSIGN = 16'h5C38;
	// Frequency words: base + ddc*8 + osc*2 (+1 for high byte), per channel
	localparam logic [15:0] ADDR_A_FREQ_BASE = 16'h5000;
	localparam logic [15:0] ADDR_B_FREQ_BASE = 16'h5800;
	localparam logic [15:0] ADDR_CONFIG = 16'h5020;

	// ******************************
	// Reset values and fields
	// ******************************
	localparam logic [7:0] CTRL_SOURCE_RESET = 8'h00;
	localparam logic [7:0] CHOICE_RESET = 8'h00;
	localparam logic [7:0] PIN_ASSIGN_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam int PIN_FIELD0_LSB = 0;
	localparam int PIN_FIELD1_LSB = 4;
	localparam int CFG_MUX_BIT = 0;
	localparam int CFG_DECIM_LSB = 4;

	// ******************************
	// Latency figures (device clock cycles, x2 for the half cycle)
	// ******************************
	localparam int LAT_BYPASS_X2 = 848;
	localparam int LAT_D4_X2 = 1032;
	localparam int LAT_D6_X2 = 1492;
	localparam int LAT_D8_X2 = 1242;
	localparam int LAT_D9_X2 = 1527;
	localparam int LAT_D10_X2 = 1622;
	localparam int LAT_D12_X2 = 1794;
	localparam int LAT_D16_X2 = 2090;
	localparam int LAT_D18_X2 = 2328;
	localparam int LAT_D20_X2 = 2512;
	localparam int LAT_D24_X2 = 2886;
	localparam int LAT_D32_X2 = 3546;
	localparam int LAT_MAX = 1773;

	typedef enum logic [3:0] {
		DECIM_BYPASS = 4'h0,
		DECIM_4 = 4'h1,
		DECIM_6 = 4'h2,
		DECIM_8 = 4'h3,
		DECIM_9 = 4'h4,
		DECIM_10 = 4'h5,
		DECIM_12 = 4'h6,
		DECIM_16 = 4'h7,
		DECIM_18 = 4'h8,
		DECIM_20 = 4'h9,
		DECIM_24 = 4'hA,
		DECIM_32 = 4'hB
	} ddcn_decim_e;

	typedef struct packed {
		logic signed [15:0] i;
		logic signed [15:0] q;
	} ddcn_iq_s;

endpackage

// File: design/ddcn_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Four independent complex oscillators per converter channel.
// - Each frequency is a signed 16-bit word; output is e^(-jwn).
// - Real samples times oscillator moves the carrier to 0 Hz.
// - Two down-converters per channel: first has three oscillators, second one.
// - First down-converter switches oscillators from register or from pins.
// - Divide-by-4 and 6 leave only one down-converter active per channel.
// - Frequency equals word times sample rate over 65536; words per ddc/osc.
// - Setting changes after link start make phase non-deterministic; reinit link.
// - Hopping works single or dual band, only on first down-converter.
// - Per-channel source choice: register (reset default) or pins.
// - Per-channel pin assignment picks two pins for select bits.
// - Assignment code 00 pin4, 01 pin1, 10 pin3, 11 pin2.
// - Select 00 osc1, 01 osc2, 10 osc3; 11 unassigned.
// - Mux mode feeds channel A data to both channels' digital blocks.
// - Mux mode keeps the same decimation and link options.
// - Bypass latency is 424 device clock cycles.
// - Total latency follows the decimation factor table.
// - Power detector tap is full-rate samples ahead of decimation.
// - Oscillators run continuously; data invalid until filters flush after switch.
// - Both chains of a channel share one decimation setting.
module ddcn_top #(
	parameter int DW = 14,
	// Longest latency, for integrators who size a delay line behind this block
	parameter int LAT_DEPTH = ddcn_pkg::LAT_MAX
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Converter samples
	input wire logic signed [DW-1:0] sample_a,
	input wire logic signed [DW-1:0] sample_b,
	// General-purpose pins 1..4 as bits 0..3
	input wire logic [3:0] gpio_in,
	// Baseband out: [channel][downconverter]
	output ddcn_pkg::ddcn_iq_s bb_out [2][2],
	output logic [1:0][1:0] bb_valid,
	output logic half_cycle_phase,
	// Power detector tap
	output logic signed [DW-1:0] pwr_tap_a,
	output logic signed [DW-1:0] pwr_tap_b
);

	// ******************************
	// Registers
	// ******************************
	// Control registers, one of each per channel, plus one shared config register
	logic [7:0] src_reg [2];
	logic [7:0] choice_reg [2];
	logic [7:0] assign_reg [2];
	logic [7:0] config_reg;
	logic [15:0] freq_reg [2][2][4]; // [chan][ddc][osc]
	logic [15:0] base [2];
	logic src_addr_hit;

	assign base[0] = ddcn_pkg::ADDR_A_FREQ_BASE;
	assign base[1] = ddcn_pkg::ADDR_B_FREQ_BASE;
	// Word d=1,o=3 high byte lands on the source register; the source wins,
	// which costs nothing because the second converter uses only word d=1,o=0
	assign src_addr_hit = (reg_addr == ddcn_pkg::ADDR_A_CTRL_SOURCE)
		|| (reg_addr == ddcn_pkg::ADDR_B_CTRL_SOURCE);

	// Register writes; frequency words per down-converter and oscillator
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_reg <= '{2{ddcn_pkg::CTRL_SOURCE_RESET}};
			choice_reg <= '{2{ddcn_pkg::CHOICE_RESET}};
			assign_reg <= '{2{ddcn_pkg::PIN_ASSIGN_RESET}};
			config_reg <= ddcn_pkg::CONFIG_RESET;
			freq_reg <= '{default: 16'h0000};
		end else if (reg_wr) begin
			if (reg_addr == ddcn_pkg::ADDR_A_CTRL_SOURCE) src_reg[0] <= reg_wdata;
			if (reg_addr == ddcn_pkg::ADDR_B_CTRL_SOURCE) src_reg[1] <= reg_wdata;
			if (reg_addr == ddcn_pkg::ADDR_A_CHOICE) choice_reg[0] <= reg_wdata;
			if (reg_addr == ddcn_pkg::ADDR_B_CHOICE) choice_reg[1] <= reg_wdata;
			if (reg_addr == ddcn_pkg::ADDR_A_PIN_ASSIGN) assign_reg[0] <= reg_wdata;
			if (reg_addr == ddcn_pkg::ADDR_B_PIN_ASSIGN) assign_reg[1] <= reg_wdata;
			if (reg_addr == ddcn_pkg::ADDR_CONFIG) config_reg <= reg_wdata;
			// Unmapped writes fall through every compare and are dropped
			for (int c = 0; c < 2; c++) begin
				for (int d = 0; d < 2; d++) begin
					for (int o = 0; o < 4; o++) begin
						// Low byte at even offset, high byte at odd
						if (reg_addr == base[c] + 16'(d * 8 + o * 2))
							freq_reg[c][d][o][7:0] <= reg_wdata;
						if (reg_addr == base[c] + 16'(d * 8 + o * 2 + 1) && !src_addr_hit)
							freq_reg[c][d][o][15:8] <= reg_wdata;
					end
				end
			end
		end
	end

	// ******************************
	// Read-back, including live oscillator state
	// ******************************
	logic [1:0] active_sel [2];
	// Combinational read; unmapped addresses return zero
	always_comb begin
		reg_rdata = 8'h00;
		unique case (reg_addr)
			ddcn_pkg::ADDR_A_CTRL_SOURCE: reg_rdata = {7'h00, src_reg[0][0]};
			ddcn_pkg::ADDR_B_CTRL_SOURCE: reg_rdata = {7'h00, src_reg[1][0]};
			ddcn_pkg::ADDR_A_CHOICE: reg_rdata = {2'b00, active_sel[0], 2'b00, choice_reg[0][1:0]};
			ddcn_pkg::ADDR_B_CHOICE: reg_rdata = {2'b00, active_sel[1], 2'b00, choice_reg[1][1:0]};
			ddcn_pkg::ADDR_A_PIN_ASSIGN: reg_rdata = assign_reg[0];
			ddcn_pkg::ADDR_B_PIN_ASSIGN: reg_rdata = assign_reg[1];
			ddcn_pkg::ADDR_CONFIG: reg_rdata = config_reg;
			default: begin
				for (int c = 0; c < 2; c++)
					for (int d = 0; d < 2; d++)
						for (int o = 0; o < 4; o++) begin
							if (reg_addr == base[c] + 16'(d * 8 + o * 2))
								reg_rdata = freq_reg[c][d][o][7:0];
							if (reg_addr == base[c] + 16'(d * 8 + o * 2 + 1))
								reg_rdata = freq_reg[c][d][o][15:8];
						end
			end
		endcase
	end

	// ******************************
	// Pin synchronisers and select logic
	// ******************************
	logic [3:0] gpio_meta_reg;
	logic [3:0] gpio_sync_reg;
	// Two flops before any logic sees a pin; only the second is read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gpio_meta_reg <= 4'h0;
			gpio_sync_reg <= 4'h0;
		end else begin
			gpio_meta_reg <= gpio_in;
			gpio_sync_reg <= gpio_meta_reg;
		end
	end

	// Assignment code to pin index (pins 1..4 are bits 0..3)
	function automatic logic pick_pin(input logic [1:0] code, input logic [3:0] pins);
		logic v;
		v = 1'b0;
		unique case (code)
			2'b00: v = pins[3];
			2'b01: v = pins[0];
			2'b10: v = pins[2];
			2'b11: v = pins[1];
		endcase
		return v;
	endfunction

	// Per-channel select state and flush counters
	logic [1:0] req_sel [2];
	logic [1:0] sel_reg [2];
	logic [1:0] sel_prev_reg [2];
	logic [11:0] flush_cnt_reg [2];
	logic [11:0] flush_len;

	for (genvar c = 0; c < 2; c++) begin : g_sel
		// Select bits from the choice register or from two assigned pins
		always_comb begin
			if (src_reg[c][0]) begin
				req_sel[c][0] = pick_pin(assign_reg[c][ddcn_pkg::PIN_FIELD0_LSB +: 2],
					gpio_sync_reg);
				req_sel[c][1] = pick_pin(assign_reg[c][ddcn_pkg::PIN_FIELD1_LSB +: 2],
					gpio_sync_reg);
			end else begin
				req_sel[c] = choice_reg[c][1:0];
			end
		end

		// Code 11 holds the previous choice rather than mute the chain
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				sel_reg[c] <= 2'b00;
				sel_prev_reg[c] <= 2'b00;
			end else begin
				if (req_sel[c] != 2'b11) sel_reg[c] <= req_sel[c];
				sel_prev_reg[c] <= sel_reg[c];
			end
		end
		// Live choice for read-back
		assign active_sel[c] = sel_reg[c];

		// Output held invalid for one filter-flush after a hop
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				flush_cnt_reg[c] <= 12'h000;
			end else if (sel_reg[c] != sel_prev_reg[c]) begin
				flush_cnt_reg[c] <= flush_len;
			end else if (flush_cnt_reg[c] != 12'h000) begin
				flush_cnt_reg[c] <= flush_cnt_reg[c] - 12'h001;
			end
		end
	end

	// ******************************
	// Channel routing, oscillators and mixers
	// ******************************
	// Routing, local oscillators and per-converter carriers
	logic mux_mode;
	ddcn_pkg::ddcn_decim_e decim;
	logic signed [DW-1:0] chan_in [2];
	ddcn_pkg::ddcn_iq_s lo [2][4];
	ddcn_pkg::ddcn_iq_s lo_sel [2][2];

	assign mux_mode = config_reg[ddcn_pkg::CFG_MUX_BIT];
	// One decimation field serves both chains and both mux settings
	assign decim = ddcn_pkg::ddcn_decim_e'(config_reg[ddcn_pkg::CFG_DECIM_LSB +: 4]);
	assign chan_in[0] = sample_a;
	assign chan_in[1] = mux_mode ? sample_a : sample_b;

	// Full-rate tap ahead of any decimation
	assign pwr_tap_a = sample_a;
	assign pwr_tap_b = chan_in[1];

	for (genvar c = 0; c < 2; c++) begin : g_chan
		// Accumulators never realign on a word change, so phase after a late
		// rewrite is arbitrary; the link partner must rebuild the link
		// Slots 0..2: first converter's three; slot 3: second converter's one
		for (genvar o = 0; o < 4; o++) begin : g_osc
			ddcn_osc #(.W(16)) u_osc (
				.clk(clk),
				.rst_n(rst_n),
				.freq_word(o < 3 ? freq_reg[c][0][o] : freq_reg[c][1][0]),
				.lo(lo[c][o])
			);
		end
		// Only the first converter hops; the second is wired to slot 3
		assign lo_sel[c][0] = lo[c][sel_reg[c]];
		assign lo_sel[c][1] = lo[c][3];
		// One mixer per down-converter
		for (genvar d = 0; d < 2; d++) begin : g_mix
			ddcn_mixer #(.DW(DW)) u_mix (
				.clk(clk),
				.rst_n(rst_n),
				.sample(chan_in[c]),
				.lo(lo_sel[c][d]),
				.bb(bb_out[c][d])
			);
		end
	end

	// ******************************
	// Latency and validity
	// ******************************
	logic [12:0] lat_x2;
	// Latency in half cycles so that divide-by-9 stays exact
	always_comb begin
		unique case (decim)
			ddcn_pkg::DECIM_4: lat_x2 = 13'(ddcn_pkg::LAT_D4_X2);
			ddcn_pkg::DECIM_6: lat_x2 = 13'(ddcn_pkg::LAT_D6_X2);
			ddcn_pkg::DECIM_8: lat_x2 = 13'(ddcn_pkg::LAT_D8_X2);
			ddcn_pkg::DECIM_9: lat_x2 = 13'(ddcn_pkg::LAT_D9_X2);
			ddcn_pkg::DECIM_10: lat_x2 = 13'(ddcn_pkg::LAT_D10_X2);
			ddcn_pkg::DECIM_12: lat_x2 = 13'(ddcn_pkg::LAT_D12_X2);
			ddcn_pkg::DECIM_16: lat_x2 = 13'(ddcn_pkg::LAT_D16_X2);
			ddcn_pkg::DECIM_18: lat_x2 = 13'(ddcn_pkg::LAT_D18_X2);
			ddcn_pkg::DECIM_20: lat_x2 = 13'(ddcn_pkg::LAT_D20_X2);
			ddcn_pkg::DECIM_24: lat_x2 = 13'(ddcn_pkg::LAT_D24_X2);
			ddcn_pkg::DECIM_32: lat_x2 = 13'(ddcn_pkg::LAT_D32_X2);
			default: lat_x2 = 13'(ddcn_pkg::LAT_BYPASS_X2);
		endcase
	end
	// Flush one full latency worth of samples; half cycle rounds up
	assign flush_len = lat_x2[12:1] + {11'h000, lat_x2[0]};
	assign half_cycle_phase = lat_x2[0];

	// Valid follows a startup wait of one full latency after config change
	logic [11:0] start_cnt_reg;
	logic [7:0] cfg_prev_reg;
	logic wide;
	// Divide-by-4 and 6 leave room for only one chain
	assign wide = (decim == ddcn_pkg::DECIM_4) || (decim == ddcn_pkg::DECIM_6);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_prev_reg <= ddcn_pkg::CONFIG_RESET;
			start_cnt_reg <= 12'(ddcn_pkg::LAT_BYPASS_X2 / 2);
		end else begin
			cfg_prev_reg <= config_reg;
			if (config_reg != cfg_prev_reg) start_cnt_reg <= flush_len;
			else if (start_cnt_reg != 12'h000) start_cnt_reg <= start_cnt_reg - 12'h001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bb_valid <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				// First chain also sits out a hop flush
				bb_valid[c][0] <= (start_cnt_reg == 12'h000) && (flush_cnt_reg[c] == 12'h000);
				bb_valid[c][1] <= (start_cnt_reg == 12'h000) && !wide;
			end
		end
	end

endmodule // ddcn_top

// File: verification/ddcn_props.sv
`timescale 1ns/100ps
// ****************
// Port checker
// ****************
module ddcn_props #(
	parameter int DW = 14
) (
	// Clock, reset, register port
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Streams
	input wire logic signed [DW-1:0] sample_a,
	input wire logic signed [DW-1:0] sample_b,
	input wire logic [1:0][1:0] bb_valid,
	input wire logic signed [DW-1:0] pwr_tap_a,
	input wire logic signed [DW-1:0] pwr_tap_b
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] cfg_reg;
	logic [1:0] sel_a_reg;
	logic [1:0] sel_b_reg;
	logic src_a_reg;
	logic [9:0] up_reg;
	logic wide;
	logic hop_a;
	logic hop_b;
	logic keep_a;
	// Shadow of writes; code 11 leaves the active choice alone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= 8'h00;
			sel_a_reg <= 2'h0;
			sel_b_reg <= 2'h0;
			src_a_reg <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == ddcn_pkg::ADDR_CONFIG) cfg_reg <= reg_wdata;
			if (reg_addr == ddcn_pkg::ADDR_A_CTRL_SOURCE) src_a_reg <= reg_wdata[0];
			if (reg_addr == ddcn_pkg::ADDR_A_CHOICE && reg_wdata[1:0] != 2'h3) sel_a_reg <= reg_wdata[1:0];
			if (reg_addr == ddcn_pkg::ADDR_B_CHOICE && reg_wdata[1:0] != 2'h3) sel_b_reg <= reg_wdata[1:0];
		end
	end
	// Cycles since reset release, saturating
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) up_reg <= 10'h000;
		else if (up_reg != 10'h3FF) up_reg <= up_reg + 10'h001;
	end
	// Decoded events
	assign wide = cfg_reg[7:4] == 4'h1 || cfg_reg[7:4] == 4'h2;
	assign hop_a = reg_wr && reg_addr == ddcn_pkg::ADDR_A_CHOICE && !src_a_reg
		&& reg_wdata[1:0] != 2'h3 && reg_wdata[1:0] != sel_a_reg;
	assign hop_b = reg_wr && reg_addr == ddcn_pkg::ADDR_B_CHOICE && reg_wdata[1:0] != 2'h3
		&& reg_wdata[1:0] != sel_b_reg;
	assign keep_a = reg_wr && reg_addr == ddcn_pkg::ADDR_A_CHOICE && reg_wdata[1:0] == 2'h3
		&& bb_valid[0][0];
	AST_PWR_TAP_A:
		assert property (pwr_tap_a == sample_a) else $error("tap A differs from sample A");
	AST_PWR_TAP_B:
		assert property (pwr_tap_b == (cfg_reg[0] ? sample_a : sample_b))
		else $error("tap B source wrong");
	AST_WIDE_ONE:
		assert property (wide [*3] |-> !bb_valid[0][1] && !bb_valid[1][1])
		else $error("second chain valid in wide mode");
	AST_STARTUP_QUIET:
		assert property (up_reg < 10'd424 |-> bb_valid == 4'h0) else $error("valid too early");
	AST_HOP_FLUSH_A:
		assert property (hop_a |-> ##4 !bb_valid[0][0] [*8]) else $error("no flush after hop A");
	AST_HOP_FLUSH_B:
		assert property (hop_b |-> ##4 !bb_valid[1][0] [*8]) else $error("no flush after hop B");
	AST_KEEP_UNASSIGNED:
		assert property (keep_a |=> bb_valid[0][0] [*4]) else $error("code 11 caused a hop");
	AST_SOURCE_READ:
		assert property (reg_addr == ddcn_pkg::ADDR_A_CTRL_SOURCE |-> reg_rdata[0] == src_a_reg)
		else $error("control source readback wrong");
	COV_HOP: cover property (hop_a);
	COV_WIDE: cover property (wide [*3]);
	COV_MUX: cover property (cfg_reg[0] && bb_valid[1][0]);
endmodule // ddcn_props

bind ddcn_top ddcn_props #(.DW(DW)) props_u (
	.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .sample_a(sample_a), .sample_b(sample_b), .bb_valid(bb_valid),
	.pwr_tap_a(pwr_tap_a), .pwr_tap_b(pwr_tap_b)
);

// File: verification/ddcn_sink.sv
`timescale 1ns/100ps
// ****************
// Link receiver model
// ****************
module ddcn_sink (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link control and stream
	input wire logic link_reinit,
	input ddcn_pkg::ddcn_iq_s bb_out [2][2],
	input wire logic [1:0][1:0] bb_valid,
	output logic [15:0] rx_count
);
	// Frame count restarts when the link is rebuilt after a setting change
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rx_count <= 16'h0000;
		else if (link_reinit) rx_count <= 16'h0000;
		else if (bb_valid[0][0]) rx_count <= rx_count + 16'h0001;
	end
endmodule // ddcn_sink

// File: verification/ddcn_top_test.sv
`timescale 1ns/100ps
// ****************
// Testbench
// ****************
module ddcn_top_test;
	logic clk, rst_n, reg_wr, link_reinit, hcp;
	logic [15:0] reg_addr, rx_count;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic signed [13:0] sample_a, sample_b, pwr_tap_a, pwr_tap_b;
	logic [3:0] gpio_in, g;
	logic [1:0] s, cur, f0, f1;
	logic [15:0] fa, fw;
	ddcn_pkg::ddcn_iq_s bb_out [2][2];
	logic [1:0][1:0] bb_valid;
	int err_count, comparisons, n, e;
	int lat [12] = '{424, 516, 746, 621, 764, 811, 897, 1045, 1164, 1256, 1443, 1773};
	logic [15:0] regs [7] = '{ddcn_pkg::ADDR_A_CTRL_SOURCE, ddcn_pkg::ADDR_A_CHOICE,
		ddcn_pkg::ADDR_A_PIN_ASSIGN, ddcn_pkg::ADDR_B_CTRL_SOURCE, ddcn_pkg::ADDR_B_CHOICE,
		ddcn_pkg::ADDR_B_PIN_ASSIGN, ddcn_pkg::ADDR_CONFIG};
	ddcn_top #(.DW(14)) dut_u (
		.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sample_a(sample_a), .sample_b(sample_b), .gpio_in(gpio_in),
		.bb_out(bb_out), .bb_valid(bb_valid), .half_cycle_phase(hcp), .pwr_tap_a(pwr_tap_a),
		.pwr_tap_b(pwr_tap_b)
	);
	ddcn_sink sink_u (
		.clk(clk), .rst_n(rst_n), .link_reinit(link_reinit), .bb_out(bb_out),
		.bb_valid(bb_valid), .rx_count(rx_count)
	);
	// Pin index behind an assignment code
	function automatic int pin_of(input logic [1:0] c);
		case (c)
			2'h0: return 3;
			2'h1: return 0;
			2'h2: return 2;
			default: return 1;
		endcase
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// Write held over one rising edge
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	// Read is combinational, sampled off the edge
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(negedge clk);
		reg_addr = a;
		#1 v = reg_rdata;
	endtask
	task automatic summarize();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Clock generator
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Fresh random samples each falling edge
	always @(negedge clk) begin
		sample_a <= 14'($urandom);
		sample_b <= 14'($urandom);
	end
	// Watchdog at about twice the expected run of some 16,000 cycles
	initial begin
		#300000;
		chk("watchdog", 0, 1);
		summarize();
	end
	// Main sequence
	initial begin
		void'($urandom(32'h681eaa79));
		{rst_n, reg_wr, link_reinit, reg_addr, reg_wdata, gpio_in} = '0;
		repeat (5) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		repeat (420) @(negedge clk);
		chk("valid in startup", 0, bb_valid);
		repeat (20) @(negedge clk);
		chk("valid after startup", 4'hF, bb_valid);
		chk("zero-frequency q", 0, bb_out[0][0].q);
		// Cosine at zero frequency is just under full scale: four times the sample
		e = $signed(bb_out[0][0].i) - 4 * sample_a;
		chk("zero-frequency i", 1, e >= -1 && e <= 1);
		$display("TEST startup done");
		foreach (regs[k]) begin
			rd(regs[k], d);
			chk("reset value", 0, d);
		end
		rd(16'h1234, d);
		chk("unmapped read", 0, d);
		// Frequency words: low byte at the even offset, high byte at the odd one
		for (int k = 0; k < 4; k++) begin
			fa = k[0] ? ddcn_pkg::ADDR_B_FREQ_BASE : ddcn_pkg::ADDR_A_FREQ_BASE;
			fa = fa + 16'(k * 4);
			fw = 16'($urandom);
			wr(fa, fw[7:0]);
			wr(fa + 16'h0001, fw[15:8]);
			rd(fa, d);
			chk("freq word low", fw[7:0], d);
			rd(fa + 16'h0001, d);
			chk("freq word high", fw[15:8], d);
		end
		$display("TEST registers done");
		// Register hops, channel A then B; code 11 must not move
		for (int ch = 0; ch < 2; ch++) begin
			cur = 2'h0;
			foreach (lat[k]) if (k < 4) begin
				s = 2'((k + 1) % 4);
				wr(ch ? ddcn_pkg::ADDR_B_CHOICE : ddcn_pkg::ADDR_A_CHOICE, {6'h00, s});
				if (s != 2'h3) cur = s;
				repeat (6) @(negedge clk);
				rd(ch ? ddcn_pkg::ADDR_B_CHOICE : ddcn_pkg::ADDR_A_CHOICE, d);
				chk("active osc", cur, d[5:4]);
				chk("flushing", s == 2'h3, bb_valid[ch][0]);
				repeat (440) @(negedge clk);
			end
		end
		$display("TEST hop done");
		wr(ddcn_pkg::ADDR_A_CTRL_SOURCE, 8'h01);
		for (int c = 0; c < 5; c++) begin
			// Last round keeps the wiring, so no stray select passes before the pins move
			f0 = (c == 4) ? 2'h3 : 2'(c);
			f1 = f0 + 2'h1;
			s = (c == 4) ? 2'h3 : 2'($urandom % 3);
			wr(ddcn_pkg::ADDR_A_PIN_ASSIGN, {2'h0, f1, 2'h0, f0});
			g = 4'($urandom);
			g[pin_of(f0)] = s[0];
			g[pin_of(f1)] = s[1];
			@(negedge clk) gpio_in = g;
			repeat (6) @(negedge clk);
			rd(ddcn_pkg::ADDR_A_CHOICE, d);
			if (s != 2'h3) cur = s;
			chk("pin osc", cur, d[5:4]);
		end
		$display("TEST pins done");
		#1 chk("tap a", sample_a, pwr_tap_a);
		chk("tap b", sample_b, pwr_tap_b);
		wr(ddcn_pkg::ADDR_CONFIG, 8'hF1); // Unused code means bypass; next write restarts
		#1 chk("mux tap b", sample_a, pwr_tap_b);
		$display("TEST mux done");
		// Every decimation code, in mux mode
		foreach (lat[c]) begin
			wr(ddcn_pkg::ADDR_CONFIG, {4'(c), 4'h1});
			repeat (2) @(negedge clk);
			chk("restart", 0, bb_valid[0][0]);
			n = 2;
			while (bb_valid[0][0] !== 1'b1 && n < 2000) begin
				@(negedge clk);
				n++;
			end
			chk("latency window", 1, n >= lat[c] - 4 && n <= lat[c] + 4);
			@(negedge clk);
			chk("second chain", !(c == 1 || c == 2), bb_valid[0][1]);
			chk("half cycle", c == 4, hcp);
		end
		$display("TEST latency done");
		link_reinit = 1'b1;
		@(negedge clk) link_reinit = 1'b0;
		repeat (10) @(negedge clk);
		chk("frames after reinit", 10, rx_count);
		$display("TEST link done");
		summarize();
	end
endmodule // ddcn_top_test
